// file: rtl/ccs_clock_ctrl.sv
// clock source selection, divider, stop control and sub-clock pin sharing
`timescale 1ns/1ns
`default_nettype none
`include "ccs_cfg.svh"

// Notes on behaviour
// - reset runs system clock from ring oscillator
// - reset leaves main clock in ceramic mode
// - rc select: ceramic off, rc on
// - rc select latched once, undone only by reset
// - sub stop bit frees pins for port
// - system and instruction clock from divider
// - sub-clock pins double as port bits
// - mode upper bits pick divide ratio
// - mode lower bits pick source, 11 refused
// - selected oscillator unstoppable, stopped unselectable
// - stop register: one bit per oscillator

module ccs_clock_ctrl
  import ccs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [`CCS_AXI_AW-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`CCS_AXI_AW-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic ring_osc_in,
  input wire logic main_osc_input_in,
  output logic ceramic_enable_out,
  output logic rc_enable_out,
  output logic ring_osc_stop_out,
  output logic main_osc_stop_out,
  output logic sub_osc_stop_out,
  input wire logic port_d_bit_six_in,
  output logic port_d_bit_six_out,
  output logic port_d_bit_six_oe_out,
  input wire logic port_d_bit_seven_in,
  output logic port_d_bit_seven_out,
  output logic port_d_bit_seven_oe_out,
  input wire logic [1:0] port_d_data_in,
  input wire logic [1:0] port_d_dir_in,
  output logic [1:0] port_d_read_out,
  output logic sys_clk_en_out,
  output logic instr_clk_en_out,
  output logic [1:0] active_src_out
);

  // ----------------------------------------------------------------------------
  // oscillator lanes
  // ----------------------------------------------------------------------------
  ccs_osc_if osc_lanes();

  assign osc_lanes.raw = {port_d_bit_seven_in, port_d_bit_six_in, main_osc_input_in, ring_osc_in};

  ccs_osc_sync u_sync (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .osc(osc_lanes)
  );

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [3:0] mode_q;
  logic [2:0] stop_q;
  logic rc_mode_q;
  ccs_src_type active_src_q;
  ccs_div_type active_div_q;
  logic [2:0] div_cnt_q;
  logic [1:0] instr_cnt_q;
  logic sys_en_q;
  logic instr_en_q;
  logic aw_held_q;
  logic w_held_q;
  logic [`CCS_AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic pin6_out_q;
  logic pin6_oe_q;
  logic pin7_out_q;
  logic pin7_oe_q;
  logic [1:0] port_read_q;

  logic do_write;
  logic mode_wr_ok;
  logic stop_wr_ok;
  logic rc_wr;
  logic [1:0] wr_resp;
  logic sel_tick;
  logic [2:0] div_mask;
  logic sys_tick;
  logic instr_tick;

  function automatic logic src_stopped(input logic [1:0] src, input logic [2:0] stop);
    src_stopped = (src == `CCS_SRC_BAD) ? 1'b1 : stop[src];
  endfunction : src_stopped

  // ----------------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------------
  assign s_axi_awready_out = !aw_held_q && !bvalid_q;
  assign s_axi_wready_out = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata_in;
      wstrb_q <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // all fields sit in byte lane 0; a write without it changes nothing
  always_comb begin
    mode_wr_ok = 1'b0;
    stop_wr_ok = 1'b0;
    rc_wr = 1'b0;
    wr_resp = `CCS_RESP_OKAY;
    if (do_write) begin
      unique case (awaddr_q)
        `CCS_OFF_MODE: begin
          if (src_stopped(wdata_q[`CCS_MODE_SRC], stop_q)) begin
            wr_resp = `CCS_RESP_SLVERR;
          end else begin
            mode_wr_ok = wstrb_q[0];
          end
        end
        `CCS_OFF_STOP: begin
          // pending or running source cannot stop
          if (wdata_q[mode_q[`CCS_MODE_SRC]] || wdata_q[active_src_q]) begin
            wr_resp = `CCS_RESP_SLVERR;
          end else begin
            stop_wr_ok = wstrb_q[0];
          end
        end
        `CCS_OFF_RC: begin
          rc_wr = wstrb_q[0];
        end
        `CCS_OFF_STAT: begin
          wr_resp = `CCS_RESP_SLVERR;
        end
        default: begin
          wr_resp = `CCS_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CCS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_resp;
    end else if (s_axi_bready_in) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // mode register reset and update
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      mode_q <= `CCS_MODE_RST;
    end else if (mode_wr_ok) begin
      mode_q <= wdata_q[3:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      stop_q <= `CCS_STOP_RST;
    end else if (stop_wr_ok) begin
      stop_q <= wdata_q[2:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rc_mode_q <= 1'b0;
    end else if (rc_wr) begin
      rc_mode_q <= 1'b1;
    end
  end

  assign ceramic_enable_out = !rc_mode_q && !stop_q[`CCS_STOP_MAIN];
  assign rc_enable_out = rc_mode_q && !stop_q[`CCS_STOP_MAIN];
  assign ring_osc_stop_out = stop_q[`CCS_STOP_RING];
  assign main_osc_stop_out = stop_q[`CCS_STOP_MAIN];
  assign sub_osc_stop_out = stop_q[`CCS_STOP_SUB];

  // ----------------------------------------------------------------------------
  // multiplexer and divider
  // ----------------------------------------------------------------------------
  // a stopped oscillator gives no ticks even if its pin still toggles
  always_comb begin
    unique case (active_src_q)
      ccs_src_ring: sel_tick = osc_lanes.tick[`CCS_LANE_RING] && !stop_q[`CCS_STOP_RING];
      ccs_src_main: sel_tick = osc_lanes.tick[`CCS_LANE_MAIN] && !stop_q[`CCS_STOP_MAIN];
      ccs_src_sub: sel_tick = osc_lanes.tick[`CCS_LANE_D6] && !stop_q[`CCS_STOP_SUB];
      default: sel_tick = 1'b0;
    endcase
  end

  always_comb begin
    unique case (active_div_q)
      ccs_div_1: div_mask = 3'h0;
      ccs_div_2: div_mask = 3'h1;
      ccs_div_4: div_mask = 3'h3;
      ccs_div_8: div_mask = 3'h7;
    endcase
  end

  // system tick from selected source through divider
  assign sys_tick = sel_tick && ((div_cnt_q & div_mask) == div_mask);
  assign instr_tick = sys_tick && (instr_cnt_q == `CCS_INSTR_LAST);

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      div_cnt_q <= 3'h0;
    end else if (sys_tick) begin
      div_cnt_q <= 3'h0;
    end else if (sel_tick) begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // new source and ratio only at a period end
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      active_src_q <= ccs_src_ring;
      active_div_q <= ccs_div_8;
    end else if (sys_tick) begin
      active_src_q <= ccs_src_type'(mode_q[`CCS_MODE_SRC]);
      active_div_q <= ccs_div_type'(mode_q[`CCS_MODE_DIV]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      instr_cnt_q <= 2'h0;
    end else if (instr_tick) begin
      instr_cnt_q <= 2'h0;
    end else if (sys_tick) begin
      instr_cnt_q <= instr_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sys_en_q <= 1'b0;
      instr_en_q <= 1'b0;
    end else begin
      sys_en_q <= sys_tick;
      instr_en_q <= instr_tick;
    end
  end

  assign sys_clk_en_out = sys_en_q;
  assign instr_clk_en_out = instr_en_q;
  assign active_src_out = active_src_q;

  // ----------------------------------------------------------------------------
  // sub-clock pins shared with port bits
  // ----------------------------------------------------------------------------
  // stop bit hands pins to port
  // pin function follows sub stop bit
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pin6_out_q <= 1'b0;
      pin6_oe_q <= 1'b0;
      pin7_out_q <= 1'b0;
      pin7_oe_q <= 1'b0;
      port_read_q <= 2'h0;
    end else begin
      pin6_out_q <= port_d_data_in[0];
      pin6_oe_q <= stop_q[`CCS_STOP_SUB] && port_d_dir_in[0];
      pin7_out_q <= port_d_data_in[1];
      pin7_oe_q <= stop_q[`CCS_STOP_SUB] && port_d_dir_in[1];
      port_read_q <= stop_q[`CCS_STOP_SUB] ?
        {osc_lanes.lvl[`CCS_LANE_D7], osc_lanes.lvl[`CCS_LANE_D6]} : 2'h0;
    end
  end

  assign port_d_bit_six_out = pin6_out_q;
  assign port_d_bit_six_oe_out = pin6_oe_q;
  assign port_d_bit_seven_out = pin7_out_q;
  assign port_d_bit_seven_oe_out = pin7_oe_q;
  assign port_d_read_out = port_read_q;

  // ----------------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready_out = !rvalid_q;

  // stop register is write-only and reads as zero
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `CCS_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_q <= 1'b1;
      rresp_q <= `CCS_RESP_OKAY;
      unique case (s_axi_araddr_in)
        `CCS_OFF_MODE: rdata_q <= {28'h0, mode_q};
        `CCS_OFF_STOP: rdata_q <= 32'h0;
        `CCS_OFF_RC: rdata_q <= 32'h0;
        `CCS_OFF_STAT: rdata_q <= {26'h0, stop_q[`CCS_STOP_SUB], rc_mode_q,
                                   active_div_q, active_src_q};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `CCS_RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_reset_state: assert property (@(posedge mclk_in) !resetn_in |=>
    active_src_q == ccs_src_ring && !rc_mode_q && stop_q == 3'h0 && mode_q == 4'hc)
    else $error("state after reset wrong");

  a_rc_latch: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    rc_mode_q |=> rc_mode_q && !ceramic_enable_out)
    else $error("rc latch undone");

  a_rc_select: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (do_write && awaddr_q == 5'h08 && wstrb_q[0] && !stop_q[1]) |=>
    rc_enable_out && !ceramic_enable_out)
    else $error("rc select without effect");

  a_ceramic_default: assert property (@(posedge mclk_in) !resetn_in |=>
    ceramic_enable_out && !rc_enable_out)
    else $error("ceramic path not active");

  a_src_legal: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    active_src_q != 2'h3 && mode_q[1:0] != 2'h3)
    else $error("illegal source code");

  a_src_refused: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (do_write && awaddr_q == 5'h00 && wdata_q[1:0] == 2'h3) |=>
    s_axi_bvalid_out && s_axi_bresp_out == 2'h2 && $stable(mode_q))
    else $error("code 11 accepted");

  a_no_stop_sel: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !stop_q[active_src_q] && !stop_q[mode_q[1:0]])
    else $error("selected oscillator stopped");

  a_switch_edge: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    ($changed(active_src_q) || $changed(active_div_q)) |-> $past(sys_tick))
    else $error("switch inside a period");

  a_div_period: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    sys_tick |-> div_cnt_q == ((3'h1 << active_div_q) - 3'h1))
    else $error("divider ratio wrong");

  a_instr_sys: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    instr_clk_en_out |-> sys_clk_en_out && $past(instr_cnt_q, 1) == 2'h2)
    else $error("instruction tick off system tick");

  a_sub_pins: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !stop_q[2] ##1 !stop_q[2] |-> !port_d_bit_six_oe_out && !port_d_bit_seven_oe_out &&
    port_d_read_out == 2'h0)
    else $error("pins driven in oscillator mode");

  a_port_handover: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    (stop_q[2] && port_d_dir_in == 2'h3) |=> port_d_bit_six_oe_out && port_d_bit_seven_oe_out)
    else $error("port not handed over");

  c_rc_switch: cover property (@(posedge mclk_in) disable iff (!resetn_in) $rose(rc_mode_q));
  c_to_main: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    active_src_q == ccs_src_main && sys_clk_en_out);
  c_port_mode: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    $rose(port_d_bit_six_oe_out));
  c_refused: cover property (@(posedge mclk_in) disable iff (!resetn_in)
    s_axi_bvalid_out && s_axi_bresp_out == 2'h2);

endmodule : ccs_clock_ctrl

`default_nettype wire

// file: rtl/ccs_cfg.svh
// offsets, field positions, reset values and counts of the clock source control
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define CCS_CLK_PERIOD_NS 20

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define CCS_AXI_AW 5
`define CCS_OFF_MODE 5'h00
`define CCS_OFF_STOP 5'h04
`define CCS_OFF_RC 5'h08
`define CCS_OFF_STAT 5'h0c

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define CCS_MODE_DIV 3:2
`define CCS_MODE_SRC 1:0
`define CCS_MODE_RST 4'hc
`define CCS_STOP_RST 3'h0
`define CCS_STOP_RING 0
`define CCS_STOP_MAIN 1
`define CCS_STOP_SUB 2
`define CCS_SRC_BAD 2'h3

// ----------------------------------------------------------------------------
// synchroniser lanes and counts
// ----------------------------------------------------------------------------
`define CCS_NUM_LANE 4
`define CCS_LANE_RING 0
`define CCS_LANE_MAIN 1
`define CCS_LANE_D6 2
`define CCS_LANE_D7 3
`define CCS_INSTR_LAST 2'h2

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define CCS_RESP_OKAY 2'h0
`define CCS_RESP_SLVERR 2'h2
`define CCS_RESP_DECERR 2'h3

`endif

// file: rtl/ccs_pkg.sv
// types of the clock source control
`default_nettype none
package ccs_pkg;

  typedef enum logic [1:0] {
    ccs_src_ring = 2'h0,
    ccs_src_main = 2'h1,
    ccs_src_sub = 2'h2
  } ccs_src_type;

  typedef enum logic [1:0] {
    ccs_div_1 = 2'h0,
    ccs_div_2 = 2'h1,
    ccs_div_4 = 2'h2,
    ccs_div_8 = 2'h3
  } ccs_div_type;

endpackage : ccs_pkg

`default_nettype wire

// file: rtl/ccs_osc_if.sv
// oscillator lanes between the pins and the clock core
`timescale 1ns/1ns
`default_nettype none
`include "ccs_cfg.svh"

interface ccs_osc_if;
  logic [`CCS_NUM_LANE-1:0] raw;
  logic [`CCS_NUM_LANE-1:0] lvl;
  logic [`CCS_NUM_LANE-1:0] tick;

  modport sync_mp(input raw, output lvl, output tick);
  modport core_mp(output raw, input lvl, input tick);
endinterface : ccs_osc_if

`default_nettype wire

// file: rtl/ccs_osc_sync.sv
// two-flop synchronisers and rising-edge ticks for oscillator and pin lanes
`timescale 1ns/1ns
`default_nettype none
`include "ccs_cfg.svh"

module ccs_osc_sync
  import ccs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  ccs_osc_if.sync_mp osc
);

  logic [`CCS_NUM_LANE-1:0] meta_q;
  logic [`CCS_NUM_LANE-1:0] sync_q;
  logic [`CCS_NUM_LANE-1:0] prev_q;

  // ----------------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------------
  // meta_q feeds sync_q only; the edge detector looks at sync_q and prev_q
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= osc.raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // raw oscillators must stay below a quarter of mclk to be seen
  assign osc.lvl = sync_q;
  assign osc.tick = sync_q & ~prev_q;

endmodule : ccs_osc_sync

`default_nettype wire

// file: verification/ccs_osc_model.sv
// partner model: on-chip, main and sub-clock oscillators
`timescale 1ns/1ns
`default_nettype none

module ccs_osc_model #(
  parameter int RING_HALF_NS = 60,
  parameter int MAIN_HALF_NS = 100,
  parameter int SUB_HALF_NS = 140
) (
  input wire logic ring_stop_in,
  input wire logic main_on_in,
  input wire logic sub_stop_in,
  output logic ring_out,
  output logic main_out,
  output logic sub_out
);
  // ------------------------------
  // oscillating circuits
  // ------------------------------
  // half periods above two bench cycles, or the synchronisers would miss edges
  // stopped circuit gives no edges
  initial begin
    ring_out = 1'b0;
    forever #RING_HALF_NS ring_out = ring_stop_in ? 1'b0 : ~ring_out;
  end
  // ceramic or rc circuit, runs while either is enabled, never an external clock
  initial begin
    main_out = 1'b0;
    forever #MAIN_HALF_NS main_out = main_on_in ? ~main_out : 1'b0;
  end
  initial begin
    sub_out = 1'b0;
    forever #SUB_HALF_NS sub_out = sub_stop_in ? 1'b0 : ~sub_out;
  end
endmodule : ccs_osc_model

`default_nettype wire

// file: verification/mcu_clock_source_control_tb.sv
// self-checking bench for the clock source control
`timescale 1ns/1ns
`default_nettype none
`include "ccs_cfg.svh"

module mcu_clock_source_control_tb;
  typedef struct packed {
    logic [`CCS_AXI_AW-1:0] a;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] m;
  } ccs_row_type;

  logic mclk_in = 1'b0, resetn_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ext6 = 1'b0, ext7 = 1'b0;
  logic [`CCS_AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0] dir = '0, pdata = '0, bresp, rresp, pread, src;
  logic awready, wready, arready, bvalid, rvalid, ceram, rc, rstop, mstop, sstop;
  logic ring, mainc, sub, o6, e6, o7, e7, sys, ins, pin6, pin7;
  int n_fail = 0, check_count = 0, gap = 99;

  ccs_row_type rows [8] = '{
    '{`CCS_OFF_MODE, 32'h0, `CCS_RESP_OKAY, 4'h0},
    '{`CCS_OFF_MODE, 32'h4, `CCS_RESP_OKAY, 4'h4},
    '{`CCS_OFF_MODE, 32'h8, `CCS_RESP_OKAY, 4'h8},
    '{`CCS_OFF_MODE, 32'hc, `CCS_RESP_OKAY, 4'hc},
    '{`CCS_OFF_MODE, 32'h3, `CCS_RESP_SLVERR, 4'hc},
    '{`CCS_OFF_STOP, 32'h1, `CCS_RESP_SLVERR, 4'hc},
    '{5'h10, 32'h0, `CCS_RESP_DECERR, 4'hc},
    '{`CCS_OFF_STAT, 32'h0, `CCS_RESP_SLVERR, 4'hc}
  };

  always #(`CCS_CLK_PERIOD_NS / 2) mclk_in = ~mclk_in;

  // pin level from whoever drives it; a stopped crystal leaves the pin to the board
  assign pin6 = (e6 === 1'b1) ? o6 : (sstop === 1'b1 ? ext6 : sub);
  assign pin7 = (e7 === 1'b1) ? o7 : ext7;

  ccs_osc_model u_osc (.ring_stop_in(rstop), .main_on_in(ceram | rc), .sub_stop_in(sstop),
    .ring_out(ring), .main_out(mainc), .sub_out(sub));

  ccs_clock_ctrl u_dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1), .ring_osc_in(ring),
    .main_osc_input_in(mainc), .ceramic_enable_out(ceram), .rc_enable_out(rc),
    .ring_osc_stop_out(rstop), .main_osc_stop_out(mstop), .sub_osc_stop_out(sstop),
    .port_d_bit_six_in(pin6), .port_d_bit_six_out(o6), .port_d_bit_six_oe_out(e6),
    .port_d_bit_seven_in(pin7), .port_d_bit_seven_out(o7), .port_d_bit_seven_oe_out(e7),
    .port_d_data_in(pdata), .port_d_dir_in(dir), .port_d_read_out(pread),
    .sys_clk_en_out(sys), .instr_clk_en_out(ins), .active_src_out(src)
  );

  task automatic test_done();
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // counts may be one period off at either end of the window
  task automatic chk_rng(input int got, input int exp);
    check_count++;
    if (got < exp - 2 || got > exp + 2) begin
      n_fail++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_rng

  task automatic wr(input logic [`CCS_AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (!b_t) begin
      @(negedge mclk_in);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = (bvalid === 1'b1);
      if (b_t) chk(32'(bresp), 32'(er));
      @(posedge mclk_in);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [`CCS_AXI_AW-1:0] a, input logic [31:0] ed,
                    input logic [1:0] er = `CCS_RESP_OKAY);
    logic ar_t, r_t;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!r_t) begin
      @(negedge mclk_in);
      ar_t = arvalid & arready;
      r_t = (rvalid === 1'b1);
      if (r_t) chk(rdata, ed);
      if (r_t) chk(32'(rresp), 32'(er));
      @(posedge mclk_in);
      if (ar_t) arvalid <= 1'b0;
    end
  endtask : rd

  // system and instruction pulses over 1200 cycles, then the source in use
  task automatic meas(input int es, input logic [1:0] esrc);
    int ns, ni;
    ns = 0;
    ni = 0;
    repeat (1200) begin
      @(negedge mclk_in);
      if (sys === 1'b1) ns++;
      if (ins === 1'b1) ni++;
    end
    chk_rng(ns, es);
    chk_rng(ni, es / 3);
    chk(32'(src), 32'(esrc));
    @(posedge mclk_in);
  endtask : meas

  task automatic reset_chk();
    resetn_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    chk(32'({ceram, rc, rstop, mstop, sstop, e6, e7, src}), 32'h100);
    @(posedge mclk_in);
    rd(`CCS_OFF_MODE, 32'hc);
  endtask : reset_chk

  // --------------------------------
  // pulses never back to back
  // --------------------------------
  always @(negedge mclk_in) begin
    if (sys === 1'b1) begin
      if (gap < 1) begin
        n_fail++;
        $display("mismatch at %0t: system pulses back to back", $time);
      end
      gap = 0;
    end else if (gap < 99) begin
      gap++;
    end
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    reset_chk();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(`CCS_OFF_MODE, 32'(rows[i].m));
      repeat (100) @(posedge mclk_in);
      rd(`CCS_OFF_STAT, 32'({rows[i].m[3:2], 2'b00}));
      meas(200 >> rows[i].m[3:2], 2'h0);
    end
    wr(`CCS_OFF_STOP, 32'h4, `CCS_RESP_OKAY);
    rd(`CCS_OFF_STOP, 32'h0);
    dir <= 2'b01;
    pdata <= 2'b01;
    ext7 <= 1'b1;
    repeat (6) @(negedge mclk_in);
    chk(32'({sstop, e6, o6, e7, pread}), 32'h3b);
    @(posedge mclk_in);
    dir <= 2'b11;
    repeat (6) @(negedge mclk_in);
    chk(32'({e7, o7, pread}), 32'h9);
    @(posedge mclk_in);
    rd(`CCS_OFF_STAT, 32'h2c);
    rd(5'h10, 32'h0, `CCS_RESP_DECERR);
    wr(`CCS_OFF_MODE, 32'h2, `CCS_RESP_SLVERR);
    wr(`CCS_OFF_STOP, 32'h0, `CCS_RESP_OKAY);
    repeat (6) @(negedge mclk_in);
    chk(32'({sstop, e6, pread}), 32'h0);
    @(posedge mclk_in);
    wr(`CCS_OFF_MODE, 32'h2, `CCS_RESP_OKAY);
    repeat (100) @(posedge mclk_in);
    meas(86, 2'h2);
    wr(`CCS_OFF_MODE, 32'h1, `CCS_RESP_OKAY);
    repeat (100) @(posedge mclk_in);
    meas(120, 2'h1);
    wr(`CCS_OFF_STOP, 32'h2, `CCS_RESP_SLVERR);
    wr(`CCS_OFF_STOP, 32'h1, `CCS_RESP_OKAY);
    @(negedge mclk_in);
    chk(32'({rstop, mstop, sstop}), 32'h4);
    @(posedge mclk_in);
    wr(`CCS_OFF_MODE, 32'h0, `CCS_RESP_SLVERR);
    reset_chk();
    wr(`CCS_OFF_RC, 32'h1, `CCS_RESP_OKAY);
    @(negedge mclk_in);
    chk(32'({ceram, rc}), 32'h1);
    @(posedge mclk_in);
    wr(`CCS_OFF_RC, 32'h1, `CCS_RESP_OKAY);
    rd(`CCS_OFF_STAT, 32'h1c);
    test_done();
  end

  // about four times the expected run
  initial begin
    repeat (60000) @(posedge mclk_in);
    n_fail++;
    test_done();
  end
endmodule : mcu_clock_source_control_tb

`default_nettype wire
